// file: inc/rsp_pkg.sv
package rsp_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;
  localparam int MEM_AW = 7;
  localparam int DIR_BIT = 7;

  // Burst wrap points
  localparam logic [7:0] CLK_RD_FIRST = 8'h00;
  localparam logic [7:0] CLK_RD_LAST = 8'h1F;
  localparam logic [7:0] RAM_RD_FIRST = 8'h20;
  localparam logic [7:0] RAM_RD_LAST = 8'h7F;
  localparam logic [7:0] CLK_WR_FIRST = 8'h80;
  localparam logic [7:0] CLK_WR_LAST = 8'h9F;
  localparam logic [7:0] RAM_WR_FIRST = 8'hA0;
  localparam logic [7:0] RAM_WR_LAST = 8'hFF;

  // Reset values and last bit index
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] BIT_RST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Timing, system clock 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 250;
  localparam int CE_SETUP_NS = 1000;
  localparam int CE_HOLD_NS = 60;
  localparam int CE_GAP_NS = 1000;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_SETUP_CYC = (CE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_HOLD_CYC = (CE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_GAP_CYC = (CE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

endpackage

// file: inc/rsp_link_if.sv
`timescale 1ns/1ps
interface rsp_link_if;
  logic ce;
  logic sclk;
  logic interface_select;
  logic ctrl_out;
  logic ctrl_oe;
  logic serial_out;
  logic serial_out_oe;
  logic serial_in;
  logic ctrl_in;
  logic din_line;
  logic dout_line;
  logic io_line;

  // Undriven lines float high; in three-wire mode both data pins form one line
  assign din_line = ctrl_oe ? ctrl_out : 1'b1;
  assign dout_line = serial_out_oe ? serial_out : 1'b1;
  assign io_line = serial_out_oe ? serial_out : din_line;
  assign serial_in = interface_select ? din_line : io_line;
  assign ctrl_in = interface_select ? dout_line : io_line;

  modport device (
    input ce,
    input sclk,
    input interface_select,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output ce,
    output sclk,
    output interface_select,
    output ctrl_out,
    output ctrl_oe,
    input ctrl_in
  );
endinterface

// file: design/rsp_device.sv
`timescale 1ns/1ps
// Contract
// - First byte after enable is the address
// - Address top bit: 0 read, 1 write
// - Single access: one byte, then enable low
// - Pointer increments after every data byte
// - Clock read burst wraps 1Fh to 00h
// - Clock write burst wraps 9Fh to 80h
// - RAM read burst wraps 7Fh to 20h
// - RAM write burst wraps FFh to A0h
// - Burst: enable held, eight clocks per byte
// - Three-wire: one shared data line, turns
// - Three-wire: least significant bit first
// - Three-wire: sample rising, change falling
// - Select pin high four-wire, low three-wire
// - Four-wire: idle clock level sets polarity
// - Four-wire: eight bits, MSB first
// - Four-wire: latch strobe edge, shift opposite
module rsp_device
(
  // System side
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Write stream toward the clock core
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [rsp_pkg::ADDR_W-1:0] wr_addr,
  output logic [rsp_pkg::BYTE_W-1:0] wr_data,
  // Status
  output logic overrun,
  output logic frame_active,
  // Link
  rsp_link_if.device link
);
  import rsp_pkg::*;

  localparam int EV_W = ADDR_W + BYTE_W;

  logic four_wire;
  logic pol_r;
  logic strobe_inv;
  logic sc;
  logic link_rst_n;
  logic [2:0] bit_cnt_r;
  logic [7:0] shin_r;
  logic [7:0] shin_nxt;
  logic addr_done_r;
  logic [7:0] addr_r;
  logic [7:0] addr_inc;
  logic byte_end;
  logic wr_byte;
  logic rd_phase;
  logic [2:0] out_idx;
  logic [7:0] rd_byte;
  logic so_r;
  logic so_oe_r;
  logic wr_tog_r;
  logic [EV_W-1:0] wr_hold_r;
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic wrap_clk_rd;
  logic wrap_ram_rd;
  logic wrap_clk_wr;
  logic wrap_ram_wr;

  // Link side, clocked by the master's serial clock
  assign four_wire = link.interface_select;
  assign strobe_inv = four_wire ? pol_r : 1'b1;
  assign sc = link.sclk ^ strobe_inv;
  assign link_rst_n = link.ce & resetn;

  // Idle clock level at the rise of enable fixes the polarity
  always_ff @(posedge link.ce or negedge resetn)
  begin
    if (!resetn)
      pol_r <= 1'b0;
    else
      pol_r <= link.sclk;
  end

  assign shin_nxt = four_wire ? {shin_r[6:0], link.serial_in} : {link.serial_in, shin_r[7:1]};
  assign byte_end = (bit_cnt_r == BIT_LAST);
  assign wr_byte = byte_end & addr_done_r & addr_r[DIR_BIT];
  assign rd_phase = addr_done_r & ~addr_r[DIR_BIT];

  assign wrap_clk_rd = (addr_r == CLK_RD_LAST);
  assign wrap_ram_rd = (addr_r == RAM_RD_LAST);
  assign wrap_clk_wr = (addr_r == CLK_WR_LAST);
  assign wrap_ram_wr = (addr_r == RAM_WR_LAST);
  assign addr_inc = wrap_clk_rd ? CLK_RD_FIRST :
                    wrap_ram_rd ? RAM_RD_FIRST :
                    wrap_clk_wr ? CLK_WR_FIRST :
                    wrap_ram_wr ? RAM_WR_FIRST : addr_r + 8'h01;

  // Strobe edge: bits in, address capture and pointer advance
  always_ff @(negedge sc or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt_r <= BIT_RST;
      shin_r <= BYTE_RST;
      addr_done_r <= 1'b0;
      addr_r <= BYTE_RST;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shin_r <= shin_nxt;
      if (byte_end && !addr_done_r)
      begin
        addr_r <= shin_nxt;
        addr_done_r <= 1'b1;
      end
      else if (byte_end)
        addr_r <= addr_inc;
    end
  end

  // Storage shared by clock and RAM: read 00h-7Fh, write 80h-FFh
  always_ff @(negedge sc)
  begin
    if (wr_byte)
      mem[addr_r[MEM_AW-1:0]] <= shin_nxt;
  end

  // Each written byte is posted to the system side by a toggle
  always_ff @(negedge sc or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_tog_r <= 1'b0;
      wr_hold_r <= '0;
    end
    else if (wr_byte)
    begin
      wr_tog_r <= ~wr_tog_r;
      wr_hold_r <= {addr_r, shin_nxt};
    end
  end

  assign rd_byte = mem[addr_r[MEM_AW-1:0]];
  assign out_idx = four_wire ? (BIT_LAST - bit_cnt_r) : bit_cnt_r;

  // Shift edge: read data out, line released when enable drops
  always_ff @(posedge sc or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else if (rd_phase)
    begin
      so_r <= rd_byte[out_idx];
      so_oe_r <= 1'b1;
    end
  end

  assign link.serial_out = so_r;
  assign link.serial_out_oe = so_oe_r;

  // System side
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_s3_r;
  logic ce_s1_r;
  logic ce_s2_r;
  logic frame_r;
  logic ev;
  logic pend_r;
  logic [EV_W-1:0] pend_d_r;
  logic [EV_W-1:0] ent0_r;
  logic [EV_W-1:0] ent1_r;
  logic v0_r;
  logic v1_r;
  logic ovr_r;
  logic pop;
  logic push;

  assign ev = tog_s2_r ^ tog_s3_r;
  assign pop = v0_r & wr_ready;
  assign push = pend_r & (~v1_r | pop);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      ce_s1_r <= 1'b0;
      ce_s2_r <= 1'b0;
      frame_r <= 1'b0;
    end
    else if (clk_en)
    begin
      tog_s1_r <= wr_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      ce_s1_r <= link.ce;
      ce_s2_r <= ce_s1_r;
      frame_r <= ce_s2_r;
    end
  end

  // A posted byte waits here until the buffer has room
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pend_r <= 1'b0;
      pend_d_r <= '0;
      ovr_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pend_r <= ev | (pend_r & ~push);
      if (ev)
        pend_d_r <= wr_hold_r;
      if (ev && pend_r && !push)
        ovr_r <= 1'b1;
    end
  end

  // Two-entry buffer, entry 0 is the head
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      ent0_r <= '0;
      ent1_r <= '0;
    end
    else if (clk_en)
    begin
      if (pop)
      begin
        v0_r <= v1_r | push;
        v1_r <= v1_r & push;
        ent0_r <= v1_r ? ent1_r : pend_d_r;
        ent1_r <= pend_d_r;
      end
      else if (push && !v0_r)
      begin
        v0_r <= 1'b1;
        ent0_r <= pend_d_r;
      end
      else if (push)
      begin
        v1_r <= 1'b1;
        ent1_r <= pend_d_r;
      end
    end
  end

  assign wr_valid = v0_r;
  assign wr_addr = ent0_r[EV_W-1:BYTE_W];
  assign wr_data = ent0_r[BYTE_W-1:0];
  assign overrun = ovr_r;
  assign frame_active = frame_r;

endmodule // rsp_device

// file: design/rsp_host.sv
`timescale 1ns/1ps
module rsp_host
#(
  parameter int HALF_CYC = rsp_pkg::SCLK_HALF_CYC,
  parameter int SETUP_CYC = rsp_pkg::CE_SETUP_CYC,
  parameter int HOLD_CYC = rsp_pkg::CE_HOLD_CYC,
  parameter int GAP_CYC = rsp_pkg::CE_GAP_CYC
)
(
  // System side
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Mode
  input wire logic four_wire,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [rsp_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [rsp_pkg::BYTE_W-1:0] cmd_len,
  // Write data
  input wire logic [rsp_pkg::BYTE_W-1:0] tx_data,
  output logic tx_take,
  // Read data
  output logic rx_valid,
  output logic [rsp_pkg::BYTE_W-1:0] rx_data,
  // Link
  rsp_link_if.host link
);
  import rsp_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_SETUP = 6'b000010,
    S_LOW = 6'b000100,
    S_HIGH = 6'b001000,
    S_TAIL = 6'b010000,
    S_GAP = 6'b100000
  } rsp_host_state_e;

  rsp_host_state_e state_r;
  logic [TMR_W-1:0] tmr_r;
  logic [2:0] bit_r;
  logic [7:0] left_r;
  logic addr_ph_r;
  logic rd_r;
  logic mode_r;
  logic [7:0] txs_r;
  logic [7:0] rxs_r;
  logic ce_r;
  logic sclk_r;
  logic mo_r;
  logic mo_oe_r;
  logic rdy_r;
  logic take_r;
  logic rxv_r;
  logic [7:0] rxd_r;
  logic rx_s1_r;
  logic rx_s2_r;
  logic tdone;
  logic [2:0] bit_nx;
  logic [7:0] rx_nxt;
  logic [7:0] next_tx;

  assign tdone = (tmr_r == '0);
  assign bit_nx = bit_r + 3'h1;
  assign rx_nxt = mode_r ? {rxs_r[6:0], rx_s2_r} : {rx_s2_r, rxs_r[7:1]};
  assign next_tx = rd_r ? BYTE_RST : tx_data;

  function automatic logic tx_bit(input logic m4, input logic [7:0] b, input logic [2:0] i);
    tx_bit = m4 ? b[BIT_LAST - i] : b[i];
  endfunction

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_s1_r <= 1'b0;
      rx_s2_r <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_s1_r <= link.ctrl_in;
      rx_s2_r <= rx_s1_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= S_IDLE;
      tmr_r <= '0;
      bit_r <= BIT_RST;
      left_r <= BYTE_RST;
      addr_ph_r <= 1'b0;
      rd_r <= 1'b0;
      mode_r <= 1'b1;
      txs_r <= BYTE_RST;
      rxs_r <= BYTE_RST;
      ce_r <= 1'b0;
      sclk_r <= 1'b0;
      mo_r <= 1'b0;
      mo_oe_r <= 1'b0;
      rdy_r <= 1'b0;
      take_r <= 1'b0;
      rxv_r <= 1'b0;
      rxd_r <= BYTE_RST;
    end
    else if (clk_en)
    begin
      take_r <= 1'b0;
      rxv_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          rdy_r <= 1'b1;
          if (cmd_valid && rdy_r)
          begin
            rdy_r <= 1'b0;
            mode_r <= four_wire;
            txs_r <= cmd_addr;
            rd_r <= ~cmd_addr[DIR_BIT];
            left_r <= cmd_len;
            addr_ph_r <= 1'b1;
            bit_r <= BIT_RST;
            mo_r <= tx_bit(four_wire, cmd_addr, BIT_RST);
            tmr_r <= TMR_W'(SETUP_CYC);
            state_r <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          // Enable rises one cycle after the mode settles, so no false link clock edge lands in a frame
          ce_r <= 1'b1;
          mo_oe_r <= 1'b1;
          if (tdone)
          begin
            tmr_r <= TMR_W'(HALF_CYC - 1);
            state_r <= S_LOW;
          end
          else
            tmr_r <= tmr_r - 1'b1;
        end
        S_LOW:
        begin
          if (tdone)
          begin
            sclk_r <= 1'b1;
            tmr_r <= TMR_W'(HALF_CYC - 1);
            state_r <= S_HIGH;
            if (!mode_r)
              rxs_r <= rx_nxt;
            if (mode_r)
              mo_r <= tx_bit(mode_r, txs_r, bit_r);
          end
          else
            tmr_r <= tmr_r - 1'b1;
        end
        S_HIGH:
        begin
          if (tdone)
          begin
            sclk_r <= 1'b0;
            tmr_r <= TMR_W'(HALF_CYC - 1);
            bit_r <= bit_nx;
            if (mode_r)
              rxs_r <= rx_nxt;
            if (bit_r != BIT_LAST)
            begin
              if (!mode_r)
                mo_r <= tx_bit(mode_r, txs_r, bit_nx);
              state_r <= S_LOW;
            end
            else
            begin
              // Shared line handed over only after the device has taken the direction bit
              if (!mode_r && addr_ph_r && rd_r)
                mo_oe_r <= 1'b0;
              if (!addr_ph_r && rd_r)
              begin
                rxv_r <= 1'b1;
                rxd_r <= mode_r ? rx_nxt : rxs_r;
              end
              if (left_r == BYTE_RST)
              begin
                tmr_r <= TMR_W'(HOLD_CYC - 1);
                state_r <= S_TAIL;
              end
              else
              begin
                left_r <= left_r - 8'h01;
                addr_ph_r <= 1'b0;
                txs_r <= next_tx;
                take_r <= ~rd_r;
                if (!mode_r)
                  mo_r <= tx_bit(mode_r, next_tx, BIT_RST);
                state_r <= S_LOW;
              end
            end
          end
          else
            tmr_r <= tmr_r - 1'b1;
        end
        S_TAIL:
        begin
          if (tdone)
          begin
            ce_r <= 1'b0;
            mo_oe_r <= 1'b0;
            tmr_r <= TMR_W'(GAP_CYC - 1);
            state_r <= S_GAP;
          end
          else
            tmr_r <= tmr_r - 1'b1;
        end
        S_GAP:
        begin
          if (tdone)
            state_r <= S_IDLE;
          else
            tmr_r <= tmr_r - 1'b1;
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  assign link.ce = ce_r;
  assign link.sclk = sclk_r;
  assign link.interface_select = mode_r;
  assign link.ctrl_out = mo_r;
  assign link.ctrl_oe = mo_oe_r;
  assign cmd_ready = rdy_r;
  assign tx_take = take_r;
  assign rx_valid = rxv_r;
  assign rx_data = rxd_r;

endmodule // rsp_host

// file: verification/rsp_link_sva.sv
`timescale 1ns/1ps
module rsp_link_sva
(
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire logic ce,
  input wire logic sclk,
  input wire logic interface_select,
  input wire logic ctrl_out,
  input wire logic ctrl_oe,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic serial_in
);
  logic sclk_r;
  logic bit_r;
  logic [7:0] bits_r;
  logic [7:0] shift_r;
  logic [7:0] addr_r;
  logic strobe;
  logic [7:0] shift_nxt;
  // Device sampling edge and bit order of the mode, seen one system clock late
  assign strobe = interface_select ? (sclk_r & ~sclk) : (~sclk_r & sclk);
  assign shift_nxt = interface_select ? {shift_r[6:0], bit_r} : {bit_r, shift_r[7:1]};
  always_ff @(posedge clk)
  begin
    sclk_r <= sclk;
    bit_r <= serial_out_oe ? serial_out : serial_in;
    if (!resetn || !ce)
      bits_r <= 8'h00;
    else if (strobe)
      bits_r <= bits_r + 8'h01;
    if (!resetn)
      shift_r <= 8'h00;
    else if (ce && strobe)
      shift_r <= shift_nxt;
    if (ce && strobe && bits_r == 8'h07)
      addr_r <= shift_nxt;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  AST_OE_IN_FRAME: assert property (serial_out_oe |-> ce)
    else $error("data output driven outside a frame");
  AST_OE_READ_ONLY: assert property ($rose(serial_out_oe) |-> bits_r >= 8'h08 && !addr_r[7])
    else $error("data output driven before a read address");
  AST_WRITE_QUIET: assert property (ce && bits_r >= 8'h08 && addr_r[7] |-> !serial_out_oe)
    else $error("data output driven during a write");
  AST_HOST_FRAMED: assert property (!ce |-> !ctrl_oe)
    else $error("host drives data outside a frame");
  AST_SCLK_IDLE: assert property (!ce |-> !sclk)
    else $error("serial clock active outside a frame");
  AST_WHOLE_BYTES: assert property ($fell(ce) |-> bits_r[2:0] == 3'h0 && bits_r >= 8'h08)
    else $error("frame ended on a partial byte");
  AST_FIRST_EDGE: assert property ($rose(ce) |-> ##[1:30] $rose(sclk))
    else $error("no clock after enable");
  AST_NO_FIGHT: assert property (!interface_select |-> !(serial_out_oe && ctrl_oe))
    else $error("both ends drive the shared line");
  AST_3W_SHIFT: assert property (!interface_select && serial_out_oe && $past(serial_out_oe)
    && $changed(serial_out) |-> $fell(sclk))
    else $error("three-wire output changed off the falling edge");
  AST_4W_SHIFT: assert property (interface_select && serial_out_oe && $past(serial_out_oe)
    && $changed(serial_out) |-> $rose(sclk))
    else $error("four-wire output changed off the shift edge");
  AST_HOST_HOLD: assert property (ce && sclk && $past(sclk) && ctrl_oe && $past(ctrl_oe)
    |-> $stable(ctrl_out))
    else $error("host data moved while clock high");
  COV_3W_READ: cover property (!interface_select && $rose(serial_out_oe));
  COV_4W_READ: cover property (interface_select && $rose(serial_out_oe));
  COV_WRITE_END: cover property ($fell(ce) && addr_r[7]);
endmodule // rsp_link_sva

// file: verification/rtc_serial_slave_port_tb.sv
`timescale 1ns/1ps
module rtc_serial_slave_port_tb;
  import rsp_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic four_wire = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [ADDR_W-1:0] cmd_addr = 8'h00;
  logic [BYTE_W-1:0] cmd_len = 8'h00;
  logic [BYTE_W-1:0] tx_data = 8'h00;
  logic tx_take;
  logic rx_valid;
  logic [BYTE_W-1:0] rx_data;
  logic wr_valid;
  logic wr_ready = 1'b0;
  logic [ADDR_W-1:0] wr_addr;
  logic [BYTE_W-1:0] wr_data;
  logic overrun;
  logic frame_active;
  logic stall = 1'b0;
  logic [7:0] mem [0:127];
  logic [7:0] tx_q [$];
  logic [15:0] wr_q [$];
  logic [7:0] rd_q [$];
  int err_count = 0;
  int check_count = 0;
  int seed = 93;

  rsp_link_if link();
  rsp_host #(.HALF_CYC(5), .SETUP_CYC(2), .HOLD_CYC(2), .GAP_CYC(2)) rsp_host_inst
  (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .four_wire(four_wire), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .tx_data(tx_data), .tx_take(tx_take),
    .rx_valid(rx_valid), .rx_data(rx_data), .link(link.host)
  );
  rsp_device rsp_device_inst
  (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .overrun(overrun), .frame_active(frame_active), .link(link.device)
  );
  rsp_link_sva rsp_link_sva_inst
  (
    .clk(clk), .resetn(resetn), .ce(link.ce), .sclk(link.sclk), .interface_select(link.interface_select),
    .ctrl_out(link.ctrl_out), .ctrl_oe(link.ctrl_oe), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .serial_in(link.serial_in)
  );

  always #25 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] next_ptr(input logic [7:0] a);
    case (a)
      8'h1F: next_ptr = 8'h00;
      8'h7F: next_ptr = 8'h20;
      8'h9F: next_ptr = 8'h80;
      8'hFF: next_ptr = 8'hA0;
      default: next_ptr = a + 8'h01;
    endcase
  endfunction

  // Random stalls on the write stream; next write byte shown after each take
  always @(negedge clk)
  begin
    wr_ready <= !stall && ($random(seed) & 3) != 0;
    if (tx_take === 1'b1 && tx_q.size() > 0)
      tx_q.delete(0);
    tx_data <= (tx_q.size() > 0) ? tx_q[0] : 8'h00;
  end

  always @(posedge clk)
  begin
    if (resetn && clk_en && wr_valid === 1'b1 && wr_ready)
      check({wr_addr, wr_data}, (wr_q.size() > 0) ? wr_q.pop_front() : 16'hXXXX);
    if (rx_valid === 1'b1)
      check({8'h00, rx_data}, (rd_q.size() > 0) ? {8'h00, rd_q.pop_front()} : 16'hXXXX);
  end

  task automatic wait_idle();
    repeat (2) @(negedge clk);
    while (cmd_ready !== 1'b1 || rd_q.size() > 0 || (wr_q.size() > 0 && !stall))
      @(negedge clk);
  endtask

  task automatic run_cmd(input logic fw, input logic [7:0] addr, input int len);
    logic [7:0] a;
    logic [7:0] last;
    a = addr;
    last = addr;
    for (int i = 0; i < len; i++)
    begin
      if (addr[DIR_BIT])
      begin
        last = 8'($random(seed));
        tx_q.push_back(last);
        mem[a[6:0]] = last;
        wr_q.push_back({a, last});
      end
      else
      begin
        last = mem[a[6:0]];
        rd_q.push_back(last);
      end
      a = next_ptr(a);
    end
    @(negedge clk);
    four_wire <= fw;
    cmd_addr <= addr;
    cmd_len <= 8'(len);
    cmd_valid <= 1'b1;
    @(posedge clk);
    while (cmd_ready !== 1'b1)
      @(posedge clk);
    @(negedge clk);
    cmd_valid <= 1'b0;
    while (rsp_link_sva_inst.bits_r < 8'h08)
      @(negedge clk);
    check({8'h00, rsp_link_sva_inst.addr_r}, {8'h00, addr});
    check({15'h0000, frame_active}, 16'h0001);
    wait_idle();
    check({15'h0000, frame_active}, 16'h0000);
    check({8'h00, rsp_link_sva_inst.shift_r}, {8'h00, last});
    $display("cmd %h len %0d done", addr, len);
  endtask

  initial
  begin
    logic [7:0] ra;
    repeat (12) @(negedge clk);
    resetn <= 1'b1;
    for (int m = 1; m >= 0; m--)
    begin
      run_cmd(m[0], 8'h9E, 3);
      run_cmd(m[0], 8'hFE, 3);
      run_cmd(m[0], 8'h1E, 3);
      run_cmd(m[0], 8'h7E, 3);
      run_cmd(m[0], 8'h05, 0);
      for (int k = 0; k < 3; k++)
      begin
        ra = 8'($random(seed)) & 8'h7F;
        run_cmd(m[0], ra | 8'h80, 1);
        run_cmd(m[0], ra, 1);
      end
    end
    // Fill the write buffer, then freeze the system side before draining
    stall <= 1'b1;
    run_cmd(1'b1, 8'hA4, 2);
    repeat (10) @(negedge clk);
    check({15'h0000, wr_valid}, 16'h0001);
    check({15'h0000, overrun}, 16'h0000);
    clk_en <= 1'b0;
    stall <= 1'b0;
    repeat (4) @(negedge clk);
    check(16'(wr_q.size()), 16'h0002);
    clk_en <= 1'b1;
    wait_idle();
    // Both entries and the pending slot full: a fourth byte sets overrun
    stall <= 1'b1;
    run_cmd(1'b1, 8'hB0, 4);
    repeat (10) @(negedge clk);
    check({15'h0000, overrun}, 16'h0001);
    wr_q.delete();
    resetn <= 1'b0;
    repeat (3) @(negedge clk);
    resetn <= 1'b1;
    stall <= 1'b0;
    repeat (2) @(negedge clk);
    check({15'h0000, overrun}, 16'h0000);
    run_cmd(1'b0, 8'h30, 3);
    finish_test();
  end

  initial
  begin
    #3000000;
    err_count++;
    finish_test();
  end
endmodule // rtc_serial_slave_port_tb
